// ### shared/ptbc_params.svh
`ifndef PTBC_PARAMS_SVH
`define PTBC_PARAMS_SVH

// Register byte offsets
`define PTBC_OFF_CTRL 8'h00
`define PTBC_OFF_PERIOD 8'h04
`define PTBC_OFF_ACTIVE 8'h08
`define PTBC_OFF_COUNT 8'h0C
`define PTBC_OFF_SEVTCMP 8'h10
`define PTBC_OFF_STATUS 8'h14
`define PTBC_OFF_MASK 8'h18

// Control register field positions
`define PTBC_B_ON 15
`define PTBC_B_UNUSED 14
`define PTBC_B_IDLE 13
`define PTBC_B_PEND 12
`define PTBC_B_ALLOW 11
`define PTBC_B_IMM 10
`define PTBC_B_POL 9
`define PTBC_B_SOUT 8
`define PTBC_B_SIN 7
`define PTBC_SRC_LSB 4
`define PTBC_PS_LSB 0

// Writable control bits: all but the unused and the pending bit
`define PTBC_CTRL_WMASK 16'hAFFF

// Interrupt status bit positions
`define PTBC_IRQ_SEVT 0
`define PTBC_IRQ_PERIOD 1
`define PTBC_IRQ_EXTSYNC 2

// Reset values
`define PTBC_RST_CTRL 16'h0000
`define PTBC_RST_PERIOD 16'hFFFF
`define PTBC_RST_SEVTCMP 16'h0000
`define PTBC_RST_IRQ 3'h0

`endif

// ### shared/ptbc_pkg.sv
package ptbc_pkg;

    typedef logic [15:0] ptbc_word_t;
    typedef logic [2:0] ptbc_irq_t;

    typedef struct packed {
        ptbc_word_t ctrl;
        ptbc_word_t period;
        ptbc_word_t activePeriod;
        ptbc_word_t count;
        ptbc_word_t sevtCmp;
        logic [3:0] postCnt;
        ptbc_irq_t irqStatus;
        ptbc_irq_t irqMask;
        logic [31:0] prdata;
        logic pslverr;
        logic syncOut;
    } ptbc_state_t;

    typedef struct packed {
        logic [7:0] stage1;
        logic [7:0] stage2;
        logic level;
        logic pulse;
    } ptbc_sync_state_t;

endpackage

// ### core/ptbc_sync_in.sv
`timescale 1ns/1ns
`default_nettype none

module ptbc_sync_in
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] syncSources,
    input wire logic [2:0] sourceSel,
    input wire logic invert,
    output logic syncPulse
);
    import ptbc_pkg::*;

    ptbc_sync_state_t stateReg;
    ptbc_sync_state_t stateNext;
    logic activeLevel;

    always_comb
    begin
        stateNext = stateReg;
        stateNext.stage1 = syncSources;
        stateNext.stage2 = stateReg.stage1;
        // Polarity applied after the synchroniser, never on the first stage
        activeLevel = stateReg.stage2[sourceSel] ^ invert;
        stateNext.level = activeLevel;
        stateNext.pulse = activeLevel & ~stateReg.level;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateReg <= '0;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign syncPulse = stateReg.pulse;

    property p_pulse_edge;
        @(posedge core_clk) disable iff (!arst_n)
        stateReg.pulse |-> stateReg.level && !$past(stateReg.level);
    endproperty
    a_pulse_edge: assert property (p_pulse_edge) else $error("sync pulse without edge");

    property p_pulse_polarity;
        @(posedge core_clk) disable iff (!arst_n)
        ($past(stateReg.stage2[sourceSel] ^ invert) && !$past(stateReg.level)) |-> stateReg.pulse;
    endproperty
    a_pulse_polarity: assert property (p_pulse_polarity) else $error("active edge missed");

endmodule

`default_nettype wire

// ### core/ptbc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptbc_params.svh"

module ptbc_top
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpuIdle,
    input wire logic syncInputPin,
    input wire logic [6:0] syncAltSources,
    output logic syncOutputPin,
    output logic [15:0] timeBaseCount,
    output logic pwmModuleOn,
    output logic specialEventIrq,
    output logic irq
);
    import ptbc_pkg::*;

    ptbc_state_t stateReg;
    ptbc_state_t stateNext;
    logic syncPulse;
    logic moduleOn;
    logic idleStop;
    logic immUpdate;
    logic syncInvert;
    logic syncOutOn;
    logic extSyncOn;
    logic [2:0] sync_source_select;
    logic [3:0] postScale;
    logic running;
    logic extSync;
    logic periodMatch;
    logic cycleStart;
    logic sevtFire;
    logic apbSetup;
    logic apbWrite;
    logic periodWrite;
    ptbc_irq_t irqEvents;

    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr == `PTBC_OFF_CTRL) || (addr == `PTBC_OFF_PERIOD) ||
                   (addr == `PTBC_OFF_ACTIVE) || (addr == `PTBC_OFF_COUNT) ||
                   (addr == `PTBC_OFF_SEVTCMP) || (addr == `PTBC_OFF_STATUS) ||
                   (addr == `PTBC_OFF_MASK);
    endfunction

    function automatic logic [31:0] readValue(input logic [7:0] addr, input ptbc_state_t s);
        logic [15:0] ctrlView;
        ctrlView = s.ctrl;
        ctrlView[`PTBC_B_UNUSED] = 1'b0;
        ctrlView[`PTBC_B_PEND] = s.irqStatus[`PTBC_IRQ_SEVT];
        case (addr)
            `PTBC_OFF_CTRL: readValue = {16'h0000, ctrlView};
            `PTBC_OFF_PERIOD: readValue = {16'h0000, s.period};
            `PTBC_OFF_ACTIVE: readValue = {16'h0000, s.activePeriod};
            `PTBC_OFF_COUNT: readValue = {16'h0000, s.count};
            `PTBC_OFF_SEVTCMP: readValue = {16'h0000, s.sevtCmp};
            `PTBC_OFF_STATUS: readValue = {29'h0000_0000, s.irqStatus};
            `PTBC_OFF_MASK: readValue = {29'h0000_0000, s.irqMask};
            default: readValue = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Control field decode

    assign moduleOn = stateReg.ctrl[`PTBC_B_ON];
    assign idleStop = stateReg.ctrl[`PTBC_B_IDLE];
    assign immUpdate = stateReg.ctrl[`PTBC_B_IMM];
    assign syncInvert = stateReg.ctrl[`PTBC_B_POL];
    assign syncOutOn = stateReg.ctrl[`PTBC_B_SOUT];
    assign extSyncOn = stateReg.ctrl[`PTBC_B_SIN];
    assign sync_source_select = stateReg.ctrl[`PTBC_SRC_LSB +: 3];
    assign postScale = stateReg.ctrl[`PTBC_PS_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////////
    // Sync input: both pin and alternate sources cross into core_clk

    ptbc_sync_in ptbc_sync_in_i
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .syncSources({syncAltSources, syncInputPin}),
        .sourceSel(sync_source_select),
        .invert(syncInvert),
        .syncPulse(syncPulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Time base

    // Settings changed while running take effect at once, except a period write with immUpdate clear; software keeps them static
    assign running = moduleOn && !(idleStop && cpuIdle);
    assign extSync = running && extSyncOn && syncPulse;
    assign periodMatch = running && (stateReg.count == stateReg.activePeriod);
    // Either event restarts the count; a period just above the sync period keeps match from firing
    assign cycleStart = extSync || periodMatch;
    assign sevtFire = running && (stateReg.count == stateReg.sevtCmp) &&
                      (stateReg.postCnt == postScale);

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && !stateReg.pslverr;
    assign periodWrite = apbWrite && (paddr == `PTBC_OFF_PERIOD);

    always_comb
    begin
        stateNext = stateReg;
        irqEvents = '0;

        if (!moduleOn)
        begin
            stateNext.count = 16'h0000;
            stateNext.postCnt = 4'h0;
            // No cycle in flight, so the shadow may pass straight through
            stateNext.activePeriod = stateReg.period;
        end
        else if (running)
        begin
            if (cycleStart)
            begin
                stateNext.count = 16'h0000;
                if (!immUpdate)
                begin
                    stateNext.activePeriod = stateReg.period;
                end
            end
            else
            begin
                stateNext.count = stateReg.count + 16'h0001;
            end
            if (stateReg.count == stateReg.sevtCmp)
            begin
                stateNext.postCnt = sevtFire ? 4'h0 : stateReg.postCnt + 4'h1;
            end
        end

        irqEvents[`PTBC_IRQ_SEVT] = sevtFire;
        irqEvents[`PTBC_IRQ_PERIOD] = periodMatch;
        irqEvents[`PTBC_IRQ_EXTSYNC] = extSync;

        // Idle (inactive) level held whenever the output is disabled
        if (moduleOn && syncOutOn)
        begin
            stateNext.syncOut = cycleStart ^ syncInvert;
        end
        else
        begin
            stateNext.syncOut = syncInvert;
        end

        if (apbSetup)
        begin
            stateNext.pslverr = !isMapped(paddr);
            stateNext.prdata = pwrite ? 32'h0000_0000 : readValue(paddr, stateReg);
        end

        if (apbWrite)
        begin
            case (paddr)
                `PTBC_OFF_CTRL:
                begin
                    stateNext.ctrl = pwdata[15:0] & `PTBC_CTRL_WMASK;
                end
                `PTBC_OFF_PERIOD:
                begin
                    stateNext.period = pwdata[15:0];
                    if (moduleOn && immUpdate)
                    begin
                        stateNext.activePeriod = pwdata[15:0];
                    end
                end
                `PTBC_OFF_SEVTCMP:
                begin
                    stateNext.sevtCmp = pwdata[15:0];
                end
                `PTBC_OFF_MASK:
                begin
                    stateNext.irqMask = pwdata[2:0];
                end
                default:
                begin
                end
            endcase
        end

        // Set beats write-one-to-clear in the same cycle
        if (apbWrite && (paddr == `PTBC_OFF_STATUS))
        begin
            stateNext.irqStatus = (stateReg.irqStatus & ~pwdata[2:0]) | irqEvents;
        end
        else
        begin
            stateNext.irqStatus = stateReg.irqStatus | irqEvents;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateReg.ctrl <= `PTBC_RST_CTRL;
            stateReg.period <= `PTBC_RST_PERIOD;
            stateReg.activePeriod <= `PTBC_RST_PERIOD;
            stateReg.count <= 16'h0000;
            stateReg.sevtCmp <= `PTBC_RST_SEVTCMP;
            stateReg.postCnt <= 4'h0;
            stateReg.irqStatus <= `PTBC_RST_IRQ;
            stateReg.irqMask <= `PTBC_RST_IRQ;
            stateReg.prdata <= 32'h0000_0000;
            stateReg.pslverr <= 1'b0;
            stateReg.syncOut <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pready = 1'b1;
    assign prdata = stateReg.prdata;
    assign pslverr = stateReg.pslverr;
    assign syncOutputPin = stateReg.syncOut;
    assign timeBaseCount = stateReg.count;
    assign pwmModuleOn = moduleOn;
    assign specialEventIrq = stateReg.irqStatus[`PTBC_IRQ_SEVT] &&
                             stateReg.ctrl[`PTBC_B_ALLOW];
    assign irq = |(stateReg.irqStatus & stateReg.irqMask);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_off_clear;
        @(posedge core_clk) disable iff (!arst_n)
        !moduleOn |=> (stateReg.count == 16'h0000) && (stateReg.postCnt == 4'h0);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("count moved while off");

    property p_unused_zero;
        @(posedge core_clk) disable iff (!arst_n)
        (apbSetup && !pwrite && paddr == `PTBC_OFF_CTRL) |=> !prdata[14] && prdata[31:16] == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit read nonzero");

    property p_idle_halt;
        @(posedge core_clk) disable iff (!arst_n)
        (moduleOn && idleStop && cpuIdle) |=> $stable(stateReg.count);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("time base ran in idle");

    property p_idle_run;
        @(posedge core_clk) disable iff (!arst_n)
        (moduleOn && !idleStop && cpuIdle && !cycleStart) |=>
            stateReg.count == $past(stateReg.count) + 16'h0001;
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("time base stopped in idle");

    property p_pending_cause;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(stateReg.irqStatus[`PTBC_IRQ_SEVT]) |-> $past(sevtFire);
    endproperty
    a_pending_cause: assert property (p_pending_cause) else $error("pending without event");

    property p_irq_allow;
        @(posedge core_clk) disable iff (!arst_n)
        (sevtFire && stateReg.ctrl[`PTBC_B_ALLOW] && !(apbWrite && paddr == `PTBC_OFF_CTRL))
            |=> specialEventIrq;
    endproperty
    a_irq_allow: assert property (p_irq_allow) else $error("special irq not raised");

    property p_irq_block;
        @(posedge core_clk) disable iff (!arst_n)
        specialEventIrq |-> stateReg.ctrl[`PTBC_B_ALLOW] && stateReg.irqStatus[`PTBC_IRQ_SEVT];
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("special irq while blocked");

    property p_imm_load;
        @(posedge core_clk) disable iff (!arst_n)
        (moduleOn && immUpdate && periodWrite) |=> stateReg.activePeriod == $past(pwdata[15:0]);
    endproperty
    a_imm_load: assert property (p_imm_load) else $error("immediate period not loaded");

    property p_boundary_load;
        @(posedge core_clk) disable iff (!arst_n)
        (moduleOn && !immUpdate && !cycleStart) |=> $stable(stateReg.activePeriod);
    endproperty
    a_boundary_load: assert property (p_boundary_load) else $error("period changed mid cycle");

    property p_sync_out;
        @(posedge core_clk) disable iff (!arst_n)
        (moduleOn && syncOutOn && cycleStart) |=> syncOutputPin != $past(syncInvert) ##1
            syncOutputPin == $past(syncInvert) || $past(cycleStart);
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("sync output pulse wrong");

    property p_sync_off;
        @(posedge core_clk) disable iff (!arst_n)
        !syncOutOn |=> syncOutputPin == $past(syncInvert);
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync output not idle");

    property p_ext_restart;
        @(posedge core_clk) disable iff (!arst_n)
        (running && extSyncOn && syncPulse) |=> stateReg.count == 16'h0000;
    endproperty
    a_ext_restart: assert property (p_ext_restart) else $error("ext sync ignored");

    property p_sevt_fire;
        @(posedge core_clk) disable iff (!arst_n)
        sevtFire |=> stateReg.irqStatus[`PTBC_IRQ_SEVT] && (stateReg.postCnt == 4'h0);
    endproperty
    a_sevt_fire: assert property (p_sevt_fire) else $error("special event not flagged");

    // Skipped matches must neither flag the event nor lose a postscaler step
    property p_post_step;
        @(posedge core_clk) disable iff (!arst_n)
        (running && stateReg.count == stateReg.sevtCmp && !sevtFire) |=>
            (stateReg.postCnt == $past(stateReg.postCnt) + 4'h1) &&
            !$rose(stateReg.irqStatus[`PTBC_IRQ_SEVT]);
    endproperty
    a_post_step: assert property (p_post_step) else $error("postscaler skipped a match");

endmodule

`default_nettype wire

// ### tb/ptbc_sync_partner.sv
`timescale 1ns/1ns
`default_nettype none

module ptbc_sync_partner
#(
    parameter int SYNC_PERIOD = 50
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic runSrc,
    input wire logic [2:0] srcSel,
    input wire logic activeLow,
    input wire logic syncOutputPin,
    output logic syncInputPin,
    output logic [6:0] syncAltSources,
    output logic [15:0] outPulses
);
    logic [7:0] phase;
    logic [7:0] lines;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase <= 8'h00;
            outPulses <= 16'h0000;
        end
        else
        begin
            phase <= (phase == 8'(SYNC_PERIOD - 1)) ? 8'h00 : phase + 8'h01;
            if (syncOutputPin == !activeLow)
            begin
                outPulses <= outPulses + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle pulse so the input synchroniser cannot miss it
    always_comb
    begin
        lines = {8{activeLow}};
        if (runSrc && phase < 8'h02)
        begin
            lines[srcSel] = !activeLow;
        end
    end

    assign syncInputPin = lines[0];
    assign syncAltSources = lines[7:1];
endmodule

`default_nettype wire

// ### tb/test_pwm_time_base_control.sv
`timescale 1ns/1ns
`default_nettype none

module test_pwm_time_base_control;
    logic core_clk, arst_n, psel, penable, pwrite, cpuIdle;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, rerr, syncInputPin, syncOutputPin;
    logic [6:0] syncAltSources;
    logic [15:0] timeBaseCount, outPulses, p, v;
    logic pwmModuleOn, specialEventIrq, irq, runSrc, activeLow;
    logic [2:0] srcSel;
    int numErrors, nChecks;

    ptbc_top ptbc_top_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle),
        .syncInputPin(syncInputPin), .syncAltSources(syncAltSources),
        .syncOutputPin(syncOutputPin), .timeBaseCount(timeBaseCount),
        .pwmModuleOn(pwmModuleOn), .specialEventIrq(specialEventIrq), .irq(irq));
    ptbc_sync_partner ptbc_sync_partner_i (.core_clk(core_clk), .arst_n(arst_n),
        .runSrc(runSrc), .srcSel(srcSel), .activeLow(activeLow),
        .syncOutputPin(syncOutputPin), .syncInputPin(syncInputPin),
        .syncAltSources(syncAltSources), .outPulses(outPulses));

    ////////////////////////////////////////////////////////////////////////
    task automatic printVerdict();
        $display("errors %0d checks %0d", numErrors, nChecks);
        if (numErrors == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e)
        begin
            numErrors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1)
        begin
            @(posedge core_clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0000_0000);
        chk(rdata, e);
    endtask

    // No local limit: a hang is caught by the watchdog
    task automatic waitCnt(input logic [15:0] c);
        while (timeBaseCount !== c)
        begin
            cyc(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic tReset();
        logic [15:0] e [7];
        e = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 7; i++)
            rdchk(8'(i * 4), {16'h0000, e[i]});
        chk(rerr, 1'h0);
    endtask

    task automatic tCtrl();
        wr(8'h00, 32'h0000_6FFF);
        rdchk(8'h00, 32'h0000_2FFF);
        chk(pwmModuleOn, 1'h0);
        wr(8'h00, 32'h0000_0000);
        rdchk(8'h1C, 32'h0000_0000);
        chk(rerr, 1'h1);
        chk(pready, 1'h1);
    endtask

    task automatic tWalk();
        wr(8'h04, 32'h0000_0002);
        wr(8'h00, 32'h0000_8000);
        chk(pwmModuleOn, 1'h1);
        waitCnt(16'h0002);
        for (int i = 0; i < 3; i++)
        begin
            cyc(1);
            chk(timeBaseCount, i);
        end
        xfer(1'h0, 8'h14, 32'h0000_0000);
        chk(rdata & 32'h0000_0002, 32'h0000_0002);
        wr(8'h00, 32'h0000_0000);
        wr(8'h14, 32'h0000_0007);
    endtask

    task automatic tPeriod();
        wr(8'h04, 32'h0000_0014);
        wr(8'h00, 32'h0000_8000);
        waitCnt(16'h0001);
        wr(8'h04, 32'h0000_001E);
        rdchk(8'h08, 32'h0000_0014);
        waitCnt(16'h0000);
        rdchk(8'h08, 32'h0000_001E);
        wr(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_0400);
        wr(8'h00, 32'h0000_8400);
        waitCnt(16'h0003);
        wr(8'h04, 32'h0000_0028);
        rdchk(8'h08, 32'h0000_0028);
        wr(8'h00, 32'h0000_0000);
    endtask

    task automatic tIdle();
        @(posedge core_clk);
        cpuIdle <= 1'h1;
        wr(8'h00, 32'h0000_A000);
        v = timeBaseCount;
        cyc(5);
        chk(timeBaseCount, v);
        wr(8'h00, 32'h0000_8000);
        waitCnt(16'h0001);
        cyc(5);
        chk(timeBaseCount, 16'h0006);
        wr(8'h00, 32'h0000_0000);
        @(posedge core_clk);
        cpuIdle <= 1'h0;
    endtask

    task automatic tSevt();
        wr(8'h14, 32'h0000_0007);
        wr(8'h04, 32'h0000_000A);
        wr(8'h10, 32'h0000_0003);
        wr(8'h00, 32'h0000_8000);
        cyc(15);
        xfer(1'h0, 8'h00, 32'h0000_0000);
        chk(rdata & 32'h0000_1000, 32'h0000_1000);
        chk(specialEventIrq, 1'h0);
        chk(irq, 1'h0);
        wr(8'h00, 32'h0000_8800);
        chk(specialEventIrq, 1'h1);
        wr(8'h18, 32'h0000_0001);
        chk(irq, 1'h1);
        wr(8'h00, 32'h0000_0800);
        wr(8'h14, 32'h0000_0007);
        rdchk(8'h00, 32'h0000_0800);
        chk(specialEventIrq, 1'h0);
        chk(irq, 1'h0);
        // Postscale 1: first compare match skipped, second one flags
        wr(8'h00, 32'h0000_0801);
        wr(8'h00, 32'h0000_8801);
        cyc(6);
        chk(specialEventIrq, 1'h0);
        cyc(12);
        chk(specialEventIrq, 1'h1);
        wr(8'h00, 32'h0000_0000);
        wr(8'h18, 32'h0000_0000);
    endtask

    // Period 10 gives an 11-cycle frame: any 33-cycle span holds 3 pulses
    task automatic pulses(input logic [31:0] ctl, input logic [15:0] e);
        wr(8'h00, ctl & 32'h0000_7FFF);
        wr(8'h00, ctl);
        cyc(2);
        p = outPulses;
        cyc(33);
        chk(outPulses - p, e);
        wr(8'h00, 32'h0000_0000);
    endtask

    task automatic tSyncOut();
        pulses(32'h0000_8100, 16'h0003);
        @(posedge core_clk);
        activeLow <= 1'h1;
        wr(8'h00, 32'h0000_0300);
        cyc(2);
        chk(syncOutputPin, 1'h1);
        pulses(32'h0000_8300, 16'h0003);
        @(posedge core_clk);
        activeLow <= 1'h0;
        pulses(32'h0000_8000, 16'h0000);
    endtask

    task automatic runMax(input logic [31:0] ctl);
        wr(8'h00, ctl & 32'h0000_7FFF);
        wr(8'h14, 32'h0000_0007);
        wr(8'h00, ctl);
        v = 16'h0000;
        repeat (160)
        begin
            cyc(1);
            if (timeBaseCount > v)
                v = timeBaseCount;
        end
    endtask

    task automatic tSyncIn();
        wr(8'h04, 32'h0000_0064);
        for (int s = 0; s < 8; s++)
        begin
            @(posedge core_clk);
            srcSel <= 3'(s);
            activeLow <= s[0];
            runSrc <= 1'h1;
            runMax(32'h0000_8080 | (s << 4) | (s[0] << 9));
            chk(v > 16'h003C, 1'h0);
            xfer(1'h0, 8'h14, 32'h0000_0000);
            chk(rdata & 32'h0000_0004, 32'h0000_0004);
        end
        runMax(32'h0000_8000 | (activeLow << 9));
        chk(v > 16'h003C, 1'h1);
        wr(8'h00, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        #3000000;
        numErrors++;
        printVerdict();
    end

    initial
    begin
        {arst_n, psel, penable, pwrite, cpuIdle, runSrc, activeLow} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        srcSel = 3'h0;
        numErrors = 0;
        nChecks = 0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'h1;
        tReset();
        tCtrl();
        tWalk();
        tPeriod();
        tIdle();
        tSevt();
        tSyncOut();
        tSyncIn();
        printVerdict();
    end
endmodule

`default_nettype wire
